// File: drive_side_model.sv
// Model of the drive fault logic and fieldbus command source
`timescale 1ns/1ps
`default_nettype none
module drive_side_model (
   // Clock
   input wire logic clock_i,
   // Commands from the bench
   input wire logic trip_i,
   input wire logic heal_i,
   input wire logic fb_i,
   // Drive side levels
   output logic event5_o = 1'b0,
   output logic cause_o = 1'b0,
   output logic fb_o = 1'b0
);
   // Event is a pulse, the cause stands until healed
   always @(posedge clock_i) begin
      event5_o <= trip_i;
      cause_o <= trip_i | (cause_o & ~heal_i);
      fb_o <= fb_i;
   end
endmodule
`default_nettype wire

// File: fault_reset_pkg.sv
// Package with register map, selector codes and carrier types for the fault reset selector
package fault_reset_pkg;

   // Register byte addresses
   localparam logic [7:0] ctrl_addr = 8'h00;
   localparam logic [7:0] select_addr = 8'h04;
   localparam logic [7:0] status_addr = 8'h08;
   localparam logic [7:0] irq_status_addr = 8'h0c;
   localparam logic [7:0] irq_mask_addr = 8'h10;
   localparam logic [7:0] other_word_addr = 8'h14;

   // Control register field positions
   localparam int ctrl_event_type_bit = 0;
   localparam int ctrl_other_bit_lsb = 8;
   localparam int other_bit_width = 5;

   // Status register field positions
   localparam int stat_tripped_bit = 0;
   localparam int stat_source_bit = 1;
   localparam int stat_event_bit = 2;
   localparam int stat_fault_bit = 3;
   localparam int stat_warn_bit = 4;

   // Interrupt event positions
   localparam int irq_trip_bit = 0;
   localparam int irq_reset_bit = 1;
   localparam int irq_refused_bit = 2;
   localparam int irq_width = 3;

   // Event type encoding
   localparam logic event_is_fault = 1'b0;
   localparam logic event_is_warning = 1'b1;

   // Selector codes
   localparam logic [7:0] sel_not_selected = 8'h00;
   localparam logic [7:0] sel_selected = 8'h01;
   localparam logic [7:0] sel_input_first = 8'h02;
   localparam logic [7:0] sel_input_last = 8'h07;
   localparam logic [7:0] sel_timed_first = 8'h12;
   localparam logic [7:0] sel_timed_last = 8'h14;
   localparam logic [7:0] sel_super_first = 8'h18;
   localparam logic [7:0] sel_super_last = 8'h1a;
   localparam logic [7:0] sel_other = 8'hff;

   // Reset values
   localparam logic [7:0] select_reset = 8'h00;
   localparam logic [31:0] ctrl_reset = 32'h0000_0000;

   // AXI responses
   localparam logic [1:0] resp_okay = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;

   // Source status words gathered together
   typedef struct packed {
      logic [5:0] input_delayed;
      logic [2:0] timed;
      logic [2:0] supervision;
      logic [31:0] other;
   } source_words_type;

   // Fault side inputs
   typedef struct packed {
      logic event5;
      logic fault_cause;
      logic fieldbus_reset;
   } fault_inputs_type;

endpackage

// File: fault_reset_select.sv
// Fault reset source selection with external event five classification and AXI4-Lite registers
// Function
// - Event five type bit: fault or warning
// - Selected source rising edge commands reset
// - Trip clears only when cause gone
// - Fieldbus reset accepted under any selector code
// - Codes 2..7 select delayed inputs 0..5
// - Codes 18..20 select timed function bits
// - Codes 24..26 select supervision bits
// - Any other word bit selectable
`timescale 1ns/1ps
`default_nettype none
module fault_reset_select (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Source status words
   input wire logic [5:0] logic_input_line_i,
   input wire logic [2:0] timed_status_i,
   input wire logic [2:0] supervision_status_i,
   // Fault side
   input wire logic event5_i,
   input wire logic fault_cause_i,
   input wire logic fieldbus_reset_i,
   // Results
   output logic event5_fault_o,
   output logic event5_warning_o,
   output logic tripped_o,
   output logic reset_pulse_o,
   output logic irq_o
);

   // Register state
   logic [31:0] ctrl;
   logic [7:0] select;
   logic [31:0] other_word;
   logic [fault_reset_pkg::irq_width-1:0] irq_status;
   logic [fault_reset_pkg::irq_width-1:0] irq_mask;
   logic [31:0] next_ctrl;
   logic [7:0] next_select;
   logic [31:0] next_other_word;
   logic [fault_reset_pkg::irq_width-1:0] next_irq_status;
   logic [fault_reset_pkg::irq_width-1:0] next_irq_mask;

   // Bus handshake state
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic next_aw_held;
   logic next_w_held;
   logic [7:0] next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0] next_w_strb;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_arready;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;

   // Fault state
   logic source_now;
   logic source_last;
   logic fieldbus_last;
   logic next_tripped;
   logic next_event5_fault;
   logic next_event5_warning;
   logic next_reset_pulse;
   logic next_irq;
   logic do_write;
   logic reset_cmd;
   logic [31:0] status_word;

   fault_reset_pkg::source_words_type words;
   fault_reset_pkg::fault_inputs_type fault_in;

   assign words = '{input_delayed: logic_input_line_i, timed: timed_status_i,
                    supervision: supervision_status_i, other: other_word};
   assign fault_in = '{event5: event5_i, fault_cause: fault_cause_i, fieldbus_reset: fieldbus_reset_i};

   // Source selection, registered inside
   reset_source_mux source_mux (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .select_i(select),
      .other_bit_i(ctrl[fault_reset_pkg::ctrl_other_bit_lsb +: fault_reset_pkg::other_bit_width]),
      .words_i(words),
      .source_o(source_now)
   );

   // Reset command: selected edge or fieldbus edge, never gated by selector
   assign reset_cmd = (source_now & ~source_last)
                    | (fault_in.fieldbus_reset & ~fieldbus_last);

   // Status word seen by software
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[fault_reset_pkg::stat_tripped_bit] = tripped_o;
      status_word[fault_reset_pkg::stat_source_bit] = source_now;
      status_word[fault_reset_pkg::stat_event_bit] = fault_in.event5;
      status_word[fault_reset_pkg::stat_fault_bit] = event5_fault_o;
      status_word[fault_reset_pkg::stat_warn_bit] = event5_warning_o;
   end

   // Fault trip, classification and interrupt events
   always_comb begin
      next_event5_fault = fault_in.event5 && (ctrl[fault_reset_pkg::ctrl_event_type_bit]
                          == fault_reset_pkg::event_is_fault);
      next_event5_warning = fault_in.event5 && (ctrl[fault_reset_pkg::ctrl_event_type_bit]
                            == fault_reset_pkg::event_is_warning);
      next_tripped = tripped_o;
      next_reset_pulse = 1'b0;
      next_irq_status = irq_status;
      if (do_write && aw_addr == fault_reset_pkg::irq_status_addr && w_strb[0]) begin
         next_irq_status = irq_status & ~w_data[fault_reset_pkg::irq_width-1:0];
      end
      // New trip wins over a reset in the same cycle, even when already tripped
      if (next_event5_fault) begin
         next_tripped = 1'b1;
         next_irq_status[fault_reset_pkg::irq_trip_bit] = 1'b1;
      end else if (reset_cmd && tripped_o) begin
         // A cause that is still present keeps the trip latched
         if (!fault_in.fault_cause) begin
            next_tripped = 1'b0;
            next_reset_pulse = 1'b1;
            next_irq_status[fault_reset_pkg::irq_reset_bit] = 1'b1;
         end else begin
            next_irq_status[fault_reset_pkg::irq_refused_bit] = 1'b1;
         end
      end
      next_irq = |(next_irq_status & irq_mask);
   end

   // Write path: address and data taken in either order
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_ctrl = ctrl;
      next_select = select;
      next_other_word = other_word;
      next_irq_mask = irq_mask;
      do_write = aw_held && w_held && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = fault_reset_pkg::resp_okay;
         for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
               case (aw_addr)
                  fault_reset_pkg::ctrl_addr: next_ctrl[b*8 +: 8] = w_data[b*8 +: 8];
                  fault_reset_pkg::other_word_addr: next_other_word[b*8 +: 8] = w_data[b*8 +: 8];
                  default: ;
               endcase
            end
         end
         case (aw_addr)
            fault_reset_pkg::ctrl_addr, fault_reset_pkg::other_word_addr,
            fault_reset_pkg::irq_status_addr: ;
            fault_reset_pkg::select_addr: begin
               if (w_strb[0]) begin
                  next_select = w_data[7:0];
               end
            end
            fault_reset_pkg::irq_mask_addr: begin
               if (w_strb[0]) begin
                  next_irq_mask = w_data[fault_reset_pkg::irq_width-1:0];
               end
            end
            fault_reset_pkg::status_addr: ;
            default: next_bresp = fault_reset_pkg::resp_slverr;
         endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
   end

   // Read path: one read at a time, answered a cycle after acceptance
   always_comb begin
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = fault_reset_pkg::resp_okay;
         case (s_axi_araddr)
            fault_reset_pkg::ctrl_addr: next_rdata = ctrl;
            fault_reset_pkg::select_addr: next_rdata = {24'h00_0000, select};
            fault_reset_pkg::status_addr: next_rdata = status_word;
            fault_reset_pkg::irq_status_addr: next_rdata = {29'h0000_0000, irq_status};
            fault_reset_pkg::irq_mask_addr: next_rdata = {29'h0000_0000, irq_mask};
            fault_reset_pkg::other_word_addr: next_rdata = other_word;
            default: begin
               next_rdata = 32'h0000_0000;
               next_rresp = fault_reset_pkg::resp_slverr;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      next_arready = !next_rvalid;
   end

   // All state registers
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl <= fault_reset_pkg::ctrl_reset;
         select <= fault_reset_pkg::select_reset;
         other_word <= 32'h0000_0000;
         irq_status <= '0;
         irq_mask <= '0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
         source_last <= 1'b1; // Avoid a false edge at release
         fieldbus_last <= 1'b1;
         tripped_o <= 1'b0;
         event5_fault_o <= 1'b0;
         event5_warning_o <= 1'b0;
         reset_pulse_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         select <= next_select;
         other_word <= next_other_word;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
         source_last <= source_now;
         fieldbus_last <= fault_in.fieldbus_reset;
         tripped_o <= next_tripped;
         event5_fault_o <= next_event5_fault;
         event5_warning_o <= next_event5_warning;
         reset_pulse_o <= next_reset_pulse;
         irq_o <= next_irq;
      end
   end

endmodule
`default_nettype wire

// File: fault_reset_select_sva.sv
// Checker of the fault reset selector ports
`timescale 1ns/1ps
`default_nettype none
module fault_reset_select_sva (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Bus answers
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Fault side
   input wire logic event5_i,
   input wire logic fault_cause_i,
   input wire logic fieldbus_reset_i,
   input wire logic event5_fault_o,
   input wire logic event5_warning_o,
   input wire logic tripped_o,
   input wire logic reset_pulse_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Outputs stay low one edge after release, so look two back
   event_class_a: assert property ($past(rst_n_i, 2) |->
      (event5_fault_o | event5_warning_o) == $past(event5_i)) else $error("event class output wrong");
   class_mutex_a: assert property (!(event5_fault_o && event5_warning_o))
      else $error("fault and warning together");
   trip_latch_a: assert property (event5_fault_o |-> ##[0:1] tripped_o)
      else $error("fault did not trip");
   pulse_single_a: assert property (reset_pulse_o |=> !reset_pulse_o)
      else $error("reset pulse too long");
   pulse_clears_a: assert property (reset_pulse_o |-> !tripped_o && $past(tripped_o))
      else $error("pulse without trip clear");
   cause_blocks_a: assert property ($fell(tripped_o) |-> !$past(fault_cause_i) || !$past(fault_cause_i, 2))
      else $error("trip cleared with cause present");
   fieldbus_reset_a: assert property ($rose(fieldbus_reset_i) && !fault_cause_i && !event5_i
      && !event5_fault_o ##1 !fault_cause_i && !event5_i |=> !tripped_o) else $error("fieldbus reset ignored");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
endmodule
bind fault_reset_select fault_reset_select_sva i_fault_reset_select_sva (.clock_i, .rst_n_i, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .event5_i, .fault_cause_i,
   .fieldbus_reset_i, .event5_fault_o, .event5_warning_o, .tripped_o, .reset_pulse_o);
`default_nettype wire

// File: reset_source_mux.sv
// Selector that routes one status bit to the external fault reset request
`timescale 1ns/1ps
`default_nettype none
module reset_source_mux (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Selection
   input wire logic [7:0] select_i,
   input wire logic [fault_reset_pkg::other_bit_width-1:0] other_bit_i,
   input wire fault_reset_pkg::source_words_type words_i,
   // Registered selected level
   output logic source_o
);

   logic next_source;

   // Pick the source bit for the current code
   always_comb begin
      next_source = 1'b0;
      if (select_i == fault_reset_pkg::sel_selected) begin
         next_source = 1'b1;
      end else if (select_i >= fault_reset_pkg::sel_input_first &&
                   select_i <= fault_reset_pkg::sel_input_last) begin
         next_source = words_i.input_delayed[3'(select_i - fault_reset_pkg::sel_input_first)];
      end else if (select_i >= fault_reset_pkg::sel_timed_first &&
                   select_i <= fault_reset_pkg::sel_timed_last) begin
         next_source = words_i.timed[2'(select_i - fault_reset_pkg::sel_timed_first)];
      end else if (select_i >= fault_reset_pkg::sel_super_first &&
                   select_i <= fault_reset_pkg::sel_super_last) begin
         next_source = words_i.supervision[2'(select_i - fault_reset_pkg::sel_super_first)];
      end else if (select_i == fault_reset_pkg::sel_other) begin
         next_source = words_i.other[other_bit_i];
      end
   end

   // Registered so the edge detector sees a clean level
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         source_o <= 1'b0;
      end else begin
         source_o <= next_source;
      end
   end

endmodule
`default_nettype wire

// File: test_fault_reset_select.sv
// Self-checking bench for the fault reset selector
`timescale 1ns/1ps
`default_nettype none
module test_fault_reset_select;
   // Clock, reset and bus
   logic clock_i = 0, rst_n_i = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0] s_axi_wstrb = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rd;
   // Sources: supervision, timed, inputs
   logic [11:0] src = 0;
   wire logic event5_i, fault_cause_i, fieldbus_reset_i;
   logic trip = 0, heal = 0, fb = 0;
   logic event5_fault_o, event5_warning_o, tripped_o, reset_pulse_o, irq_o;
   int err_total = 0, n_checks = 0, pulses = 0, warns = 0, faults = 0, np = 0, seed = 49;

   always #25 clock_i = ~clock_i;
   // Count one-cycle outputs edge by edge
   always @(posedge clock_i) begin
      pulses += int'(reset_pulse_o === 1'b1);
      warns += int'(event5_warning_o === 1'b1);
      faults += int'(event5_fault_o === 1'b1);
   end

   drive_side_model i_drive_side_model (.clock_i, .trip_i(trip), .heal_i(heal), .fb_i(fb),
      .event5_o(event5_i), .cause_o(fault_cause_i), .fb_o(fieldbus_reset_i));
   fault_reset_select i_fault_reset_select (.clock_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .logic_input_line_i(src[5:0]), .timed_status_i(src[8:6]), .supervision_status_i(src[11:9]),
      .event5_i, .fault_cause_i, .fieldbus_reset_i, .event5_fault_o, .event5_warning_o, .tripped_o,
      .reset_pulse_o, .irq_o);

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      if (err_total == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      int lag;
      aw = 0;
      w = 0;
      lag = $unsigned($random(seed)) % 4;
      @(posedge clock_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (!(aw && w)) begin
         @(posedge clock_i);
         if (s_axi_awready === 1'b1 && !aw) begin
            aw = 1;
            s_axi_awvalid <= 0;
         end
         if (s_axi_wready === 1'b1 && !w) begin
            w = 1;
            s_axi_wvalid <= 0;
         end
      end
      // Late bready now and then, so the answer must stand
      repeat (lag) @(posedge clock_i);
      s_axi_bready <= 1;
      do @(posedge clock_i); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 0;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      int lag;
      lag = $unsigned($random(seed)) % 3;
      @(posedge clock_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= (lag == 0);
      do @(posedge clock_i); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      // Random rready lag keeps the read data standing a while
      repeat (lag) @(posedge clock_i);
      s_axi_rready <= 1;
      do @(posedge clock_i); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 0;
   endtask

   // One-cycle command to the drive side, then settle
   task automatic drive(input logic t, input logic h, input logic f);
      @(posedge clock_i);
      trip <= t;
      heal <= h;
      fb <= f;
      @(posedge clock_i);
      trip <= 0;
      heal <= 0;
      fb <= 0;
      repeat (4) @(posedge clock_i);
   endtask

   // Source bit k answers to this selector code
   function automatic logic [7:0] code_of(input int k);
      if (k < 6) return 8'h02 + 8'(k);
      if (k < 9) return 8'h12 + 8'(k - 6);
      return 8'h18 + 8'(k - 9);
   endfunction

   initial begin
      int k, idx;
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1;
      repeat (2) @(posedge clock_i);
      rd_reg(fault_reset_pkg::select_addr);
      chk("select reset", 32'h0, rd);
      rd_reg(fault_reset_pkg::irq_mask_addr);
      chk("mask reset", 32'h0, rd);
      rd_reg(8'h1c);
      chk("unmapped read", 32'h2, {30'h0, resp});
      wr(8'h1c, 32'h1);
      chk("unmapped write", 32'h2, {30'h0, resp});
      // Warning type never trips
      wr(fault_reset_pkg::ctrl_addr, 32'h1);
      drive(1, 0, 0);
      chk("warnings", 32'h1, 32'(warns));
      chk("trip on warning", 32'h0, 32'(tripped_o));
      chk("faults on warning", 32'h0, 32'(faults));
      drive(0, 1, 0);
      wr(fault_reset_pkg::ctrl_addr, 32'h0);
      // Code 0 gives no edge, code 1 one edge that the cause refuses; fieldbus waits for the cause to clear
      drive(1, 0, 0);
      chk("fault trip", 32'h1, 32'(tripped_o));
      chk("fault events", 32'h1, 32'(faults));
      rd_reg(fault_reset_pkg::status_addr);
      chk("status word", 32'h1 << fault_reset_pkg::stat_tripped_bit, rd);
      src <= 12'hfff;
      repeat (3) @(posedge clock_i);
      chk("code 0", 32'h1, 32'(tripped_o));
      wr(fault_reset_pkg::select_addr, 32'h1);
      repeat (3) @(posedge clock_i);
      chk("code 1", 32'h1, 32'(tripped_o));
      drive(0, 0, 1);
      chk("cause present", 32'h1, 32'(tripped_o));
      drive(0, 1, 1);
      np++;
      chk("fieldbus reset", 32'h0, 32'(tripped_o));
      // Each listed code routes only its own bit, random neighbours held
      for (k = 0; k < 12; k++) begin
         drive(1, 0, 0);
         src <= 12'($random(seed)) & ~(12'h1 << k);
         wr(fault_reset_pkg::select_addr, 32'(code_of(k)));
         drive(0, 1, 0);
         chk("no edge yet", 32'h1, 32'(tripped_o));
         src[k] <= 1'b1;
         repeat (4) @(posedge clock_i);
         np++;
         chk("routed reset", 32'h0, 32'(tripped_o));
         chk("pulses", 32'(np), 32'(pulses));
      end
      // Any bit of the other word
      idx = $unsigned($random(seed)) % 32;
      drive(1, 0, 0);
      wr(fault_reset_pkg::other_word_addr, 32'h0);
      wr(fault_reset_pkg::ctrl_addr, 32'(idx) << 8);
      wr(fault_reset_pkg::select_addr, 32'hff);
      drive(0, 1, 0);
      wr(fault_reset_pkg::other_word_addr, 32'h1 << idx);
      repeat (4) @(posedge clock_i);
      chk("other bit", 32'h0, 32'(tripped_o));
      // Sticky events, mask, level output, write one to clear
      rd_reg(fault_reset_pkg::irq_status_addr);
      chk("irq status", 32'h7, rd);
      chk("irq masked", 32'h0, 32'(irq_o));
      wr(fault_reset_pkg::irq_mask_addr, 32'h7);
      repeat (2) @(posedge clock_i);
      chk("irq raised", 32'h1, 32'(irq_o));
      wr(fault_reset_pkg::irq_status_addr, 32'h7);
      repeat (2) @(posedge clock_i);
      chk("irq cleared", 32'h0, 32'(irq_o));
      rd_reg(fault_reset_pkg::irq_status_addr);
      chk("irq status clear", 32'h0, rd);
      tally_and_finish();
   end

   // Sequence needs a few hundred cycles; cut a hang well after
   initial begin
      #(50 * 20000);
      err_total++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
